// file: src/mms_pkg.sv
// Shared constants of the measurement mode sequencer.
// Assumes a 100 MHz clock and a classic Wishbone slave port.
package mms_pkg;
	// Clock and time base
	localparam int CLOCK_HZ = 100_000_000;
	localparam int SECOND_S = 1;
	localparam int CYCLES_PER_SECOND = SECOND_S * CLOCK_HZ;
	localparam int WEEK_S = 604_800;
	localparam int SERVICE_NS = 160;
	localparam int SERVICE_CYCLES = SERVICE_NS / (1_000_000_000 / CLOCK_HZ);
	localparam int BOOT_CYCLES = 3;
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PERIOD = 8'h04;
	localparam logic [7:0] ADDR_PRESS_HIGH = 8'h08;
	localparam logic [7:0] ADDR_PRESS_LOW = 8'h0C;
	localparam logic [7:0] ADDR_SETPOINT = 8'h10;
	localparam logic [7:0] ADDR_RESULT = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_OFFSET = 8'h1C;
	// Control fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_AUTO_BASELINE_CORRECTION_BIT = 2;
	// Status fields
	localparam int STS_ACTIVE_BIT = 0;
	localparam int STS_READY_BIT = 1;
	localparam int STS_MODE_LSB = 2;
	localparam int STS_MEASURE_BIT = 4;
	localparam int STS_OFFSET_BIT = 5;
	// Reset values and limits
	localparam logic [11:0] PERIOD_RESET = 12'h03C;
	localparam logic [11:0] PERIOD_MIN = 12'h005;
	localparam logic [15:0] PRESS_RESET = 16'h03F5;
	localparam logic [15:0] PRESS_NOMINAL = 16'h03F5;
	localparam logic [15:0] SETPOINT_RESET = 16'h0190;
	localparam logic [15:0] CONC_MAX = 16'hFFFF;
	// Operating modes
	typedef enum logic [1:0] {
		MODE_IDLE = 2'b00,
		MODE_CONTINUOUS = 2'b01,
		MODE_SINGLE = 2'b10
	} mms_mode_t;
	// Sequencer states
	typedef enum logic [2:0] {
		ST_INACTIVE = 3'b000,
		ST_SERVICE = 3'b001,
		ST_MEASURE = 3'b010,
		ST_COMPENSATE = 3'b011,
		ST_STORE = 3'b100
	} mms_state_t;
endpackage

// file: src/mms_second_tick.sv
// One-cycle pulse once per programmed number of clock cycles.
// Assumes a free-running clock and a synchronous reset.
`timescale 1ns/1ps
module mms_second_tick #(
	parameter int CYCLES = 100_000_000
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Tick
	output logic tick
);
	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);

	logic [W-1:0] count;

	always_ff @(posedge clock) begin
		if (reset) begin
			count <= '0;
			tick <= 1'b0;
		end else if (count == LAST) begin
			count <= '0;
			tick <= 1'b1;
		end else begin
			count <= count + W'(1);
			tick <= 1'b0;
		end
	end
endmodule

// file: src/mms_pressure_comp.sv
// Scales a raw concentration by reference pressure over nominal pressure.
// Assumes start is a pulse given only while idle; takes 33 cycles.
`timescale 1ns/1ps
module mms_pressure_comp
	import mms_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Request
	input wire logic start,
	input wire logic [15:0] raw,
	input wire logic [15:0] pressure,
	// Answer
	output logic done,
	output logic [15:0] result
);
	// Restoring divide keeps area small; speed is no concern here
	logic [31:0] dividend;
	logic [31:0] quotient;
	logic [16:0] remain;
	logic [5:0] step;
	logic busy;
	logic [16:0] trial;

	assign trial = {remain[15:0], dividend[31]};

	always_ff @(posedge clock) begin
		if (reset) begin
			dividend <= '0;
			quotient <= '0;
			remain <= '0;
			step <= '0;
			busy <= 1'b0;
			done <= 1'b0;
			result <= '0;
		end else if (start) begin
			// A zero pressure means none was given: stay uncompensated
			dividend <= raw * ((pressure == 16'h0000) ? PRESS_NOMINAL : pressure);
			quotient <= '0;
			remain <= '0;
			step <= '0;
			busy <= 1'b1;
			done <= 1'b0;
		end else if (busy) begin
			dividend <= {dividend[30:0], 1'b0};
			if (trial >= {1'b0, PRESS_NOMINAL}) begin
				remain <= trial - {1'b0, PRESS_NOMINAL};
				quotient <= {quotient[30:0], 1'b1};
			end else begin
				remain <= trial;
				quotient <= {quotient[30:0], 1'b0};
			end
			step <= step + 6'h01;
			busy <= (step != 6'h1F);
		end else begin
			done <= (step == 6'h20);
			step <= '0;
			result <= (quotient[31:16] != 16'h0000) ? CONC_MAX
				: quotient[15:0];
		end
	end
endmodule

// file: src/mms_sequencer.sv
// Measurement mode sequencer: power state, modes, post-processing.
// Assumes a Wishbone classic master and a measurement front end that
// answers each seqStart pulse with one seqDone pulse and rawConc.
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Function
// - Always either active or inactive; inactive once no task remains.
// - Inactive device wakes on service requests, continuous-mode triggers and single-shot starts.
// - Host writes the operating-mode field; the device adopts it.
// - Idle mode never measures; brief active service, then inactive again.
// - Continuous mode measures periodically, sleeping between sequences.
// - Period programmable in whole seconds, 5 to 4095.
// - Single-shot runs one sequence then returns itself to idle.
// - Pulse-disable pin high at power-up means start in idle.
// - Pressure reference high/low bytes compensate every stored result.
// - Baseline offset recomputed weekly when enabled, applied afterwards.
module mms_sequencer
	import mms_pkg::*;
#(
	parameter int TICK_CYCLES = CYCLES_PER_SECOND,
	parameter int WEEK_SECONDS = WEEK_S
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Wishbone slave
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [7:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [31:0] wbDatW,
	output logic [31:0] wbDatR,
	output logic wbAck,
	// Measurement front end
	output logic seqStart,
	input wire logic seqDone,
	input wire logic [15:0] rawConc,
	// Service request from interrupt sources
	input wire logic serviceReq,
	// Configuration pin and power state
	input wire logic pulse_output_disable_pin,
	output logic powerActive
);
	import mms_pkg::*;

	localparam int WEEK_W = $clog2(WEEK_SECONDS + 1);
	localparam logic [WEEK_W-1:0] WEEK_LAST = WEEK_W'(WEEK_SECONDS - 1);

	function automatic logic [31:0] mergeBytes(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] sel);
		logic [31:0] merged;
		merged = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				merged[8*i +: 8] = data[8*i +: 8];
			end
		end
		return merged;
	endfunction

	// Bus
	logic access;
	logic writeStrobe;
	logic readStrobe;
	logic [31:0] writeCtrl;
	// Registers
	mms_mode_t operating_mode_field;
	logic auto_baseline_correction;
	logic [11:0] period;
	logic [7:0] pressure_reference_high;
	logic [7:0] pressure_reference_low;
	logic [15:0] setpoint;
	logic [15:0] result;
	logic resultReady;
	// Sequencer
	mms_state_t state;
	mms_state_t next_state;
	logic [7:0] serviceCount;
	logic secondTick;
	logic [11:0] secCount;
	logic [11:0] periodEff;
	logic measurePending;
	logic compDone;
	logic [15:0] compConc;
	logic [15:0] finalConc;
	logic storeNow;
	// Baseline correction
	logic [WEEK_W-1:0] weekCount;
	logic [15:0] weekMin;
	logic [16:0] offset;
	logic offsetValid;
	logic [17:0] corrected;
	// Configuration pin
	logic pinS1;
	logic pinS2;
	logic pinS3;
	logic pinLevel;
	logic [2:0] bootCount;
	logic bootDecide;

	// Bus decode: ack one cycle after the request, dropped after one cycle
	assign access = wbCyc && wbStb && !wbAck;
	assign writeStrobe = access && wbWe;
	assign readStrobe = access && !wbWe;
	assign writeCtrl = mergeBytes({29'h0, auto_baseline_correction,
		operating_mode_field}, wbDatW, wbSel);

	always_ff @(posedge clock) begin
		if (reset) begin
			wbAck <= 1'b0;
		end else begin
			wbAck <= access;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			wbDatR <= '0;
		end else if (readStrobe) begin
			unique case (wbAdr)
				ADDR_CTRL: wbDatR <= {29'h0, auto_baseline_correction,
					operating_mode_field};
				ADDR_PERIOD: wbDatR <= {20'h0, period};
				ADDR_PRESS_HIGH: wbDatR <= {24'h0, pressure_reference_high};
				ADDR_PRESS_LOW: wbDatR <= {24'h0, pressure_reference_low};
				ADDR_SETPOINT: wbDatR <= {16'h0, setpoint};
				ADDR_RESULT: wbDatR <= {16'h0, result};
				ADDR_STATUS: begin
					wbDatR <= '0;
					wbDatR[STS_ACTIVE_BIT] <= powerActive;
					wbDatR[STS_READY_BIT] <= resultReady;
					wbDatR[STS_MODE_LSB +: 2] <= operating_mode_field;
					wbDatR[STS_MEASURE_BIT] <= (state == ST_MEASURE);
					wbDatR[STS_OFFSET_BIT] <= offsetValid;
				end
				ADDR_OFFSET: wbDatR <= {{15{offset[16]}}, offset};
				default: wbDatR <= '0;
			endcase
		end
	end

	// Pin passes three flops; a change counts once the last two agree
	always_ff @(posedge clock) begin
		if (reset) begin
			pinS1 <= 1'b1;
			pinS2 <= 1'b1;
			pinS3 <= 1'b1;
			pinLevel <= 1'b1;
		end else begin
			pinS1 <= pulse_output_disable_pin;
			pinS2 <= pinS1;
			pinS3 <= pinS2;
			if (pinS2 == pinS3) begin
				pinLevel <= pinS3;
			end
		end
	end

	// The pin is judged once, after a low level has passed the agree stage
	always_ff @(posedge clock) begin
		if (reset) begin
			bootCount <= '0;
			bootDecide <= 1'b0;
		end else begin
			bootDecide <= (bootCount == 3'(BOOT_CYCLES));
			if (bootCount != 3'(BOOT_CYCLES + 1)) begin
				bootCount <= bootCount + 3'h1;
			end
		end
	end

	// Operating mode: host write wins over the automatic return to idle
	always_ff @(posedge clock) begin
		if (reset) begin
			operating_mode_field <= MODE_IDLE;
			auto_baseline_correction <= 1'b0;
		end else if (writeStrobe && wbAdr == ADDR_CTRL) begin
			operating_mode_field <=
				mms_mode_t'(writeCtrl[CTRL_MODE_LSB +: 2]);
			auto_baseline_correction <= writeCtrl[CTRL_AUTO_BASELINE_CORRECTION_BIT];
		end else if (storeNow && operating_mode_field == MODE_SINGLE) begin
			operating_mode_field <= MODE_IDLE;
		end else if (bootDecide && !pinLevel) begin
			operating_mode_field <= MODE_CONTINUOUS;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			period <= PERIOD_RESET;
			pressure_reference_high <= PRESS_RESET[15:8];
			pressure_reference_low <= PRESS_RESET[7:0];
			setpoint <= SETPOINT_RESET;
		end else if (writeStrobe) begin
			unique case (wbAdr)
				ADDR_PERIOD: period <= 12'(mergeBytes({20'h0, period},
					wbDatW, wbSel));
				ADDR_PRESS_HIGH: pressure_reference_high <=
					8'(mergeBytes({24'h0, pressure_reference_high},
					wbDatW, wbSel));
				ADDR_PRESS_LOW: pressure_reference_low <=
					8'(mergeBytes({24'h0, pressure_reference_low},
					wbDatW, wbSel));
				ADDR_SETPOINT: setpoint <= 16'(mergeBytes({16'h0, setpoint},
					wbDatW, wbSel));
				default: ;
			endcase
		end
	end

	// Period timing; a short period is held at the least legal value
	mms_second_tick #(
		.CYCLES(TICK_CYCLES)
	) secondTimer (
		.clock(clock),
		.reset(reset),
		.tick(secondTick)
	);

	assign periodEff = (period < PERIOD_MIN) ? PERIOD_MIN : period;

	always_ff @(posedge clock) begin
		if (reset) begin
			secCount <= '0;
		end else if (operating_mode_field != MODE_CONTINUOUS) begin
			secCount <= '0;
		end else if (secondTick) begin
			secCount <= (secCount + 12'h001 >= periodEff) ? 12'h000
				: secCount + 12'h001;
		end
	end

	// Pending measurement: set wins over the clear at sequence start
	always_ff @(posedge clock) begin
		if (reset) begin
			measurePending <= 1'b0;
		end else if (writeStrobe && wbAdr == ADDR_CTRL
			&& writeCtrl[CTRL_MODE_LSB +: 2] == MODE_SINGLE) begin
			measurePending <= 1'b1;
		end else if (operating_mode_field == MODE_CONTINUOUS && secondTick
			&& secCount + 12'h001 >= periodEff) begin
			measurePending <= 1'b1;
		end else if (operating_mode_field == MODE_IDLE) begin
			measurePending <= 1'b0;
		end else if (state == ST_INACTIVE || state == ST_SERVICE) begin
			measurePending <= measurePending && (next_state != ST_MEASURE);
		end
	end

	// Power state machine
	always_comb begin
		next_state = state;
		unique case (state)
			ST_INACTIVE: begin
				if (measurePending && operating_mode_field != MODE_IDLE) begin
					next_state = ST_MEASURE;
				end else if (serviceReq) begin
					next_state = ST_SERVICE;
				end
			end
			ST_SERVICE: begin
				if (serviceCount == 8'(SERVICE_CYCLES)) begin
					next_state = ST_INACTIVE;
				end
			end
			ST_MEASURE: begin
				if (seqDone) begin
					next_state = ST_COMPENSATE;
				end
			end
			ST_COMPENSATE: begin
				if (compDone) begin
					next_state = ST_STORE;
				end
			end
			ST_STORE: next_state = ST_INACTIVE;
			default: next_state = ST_INACTIVE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state <= ST_INACTIVE;
			serviceCount <= '0;
			seqStart <= 1'b0;
			powerActive <= 1'b0;
		end else begin
			state <= next_state;
			serviceCount <= (next_state == ST_SERVICE)
				? serviceCount + 8'h01 : 8'h00;
			seqStart <= (state != ST_MEASURE) && (next_state == ST_MEASURE);
			powerActive <= (next_state != ST_INACTIVE);
		end
	end

	// Pressure compensation on every finished sequence
	mms_pressure_comp pressureComp (
		.clock(clock),
		.reset(reset),
		.start(state == ST_MEASURE && seqDone),
		.raw(rawConc),
		.pressure({pressure_reference_high, pressure_reference_low}),
		.done(compDone),
		.result(compConc)
	);

	// Baseline offset applied only once one has been computed
	assign corrected = {2'b00, compConc} + {offset[16], offset};
	assign finalConc = !(auto_baseline_correction && offsetValid) ? compConc
		: corrected[17] ? 16'h0000
		: corrected[16] ? CONC_MAX : corrected[15:0];
	assign storeNow = (state == ST_STORE);

	// Weekly offset: the week's lowest reading is taken as the baseline
	always_ff @(posedge clock) begin
		if (reset) begin
			weekCount <= '0;
			weekMin <= CONC_MAX;
			offset <= '0;
			offsetValid <= 1'b0;
		end else begin
			if (secondTick) begin
				weekCount <= (weekCount == WEEK_LAST) ? '0
					: weekCount + WEEK_W'(1);
			end
			if (secondTick && weekCount == WEEK_LAST) begin
				weekMin <= CONC_MAX;
				if (auto_baseline_correction && weekMin != CONC_MAX) begin
					offset <= {1'b0, setpoint} - {1'b0, weekMin};
					offsetValid <= 1'b1;
				end
			end else if (storeNow && compConc < weekMin) begin
				weekMin <= compConc;
			end
		end
	end

	// Result only after every step; ready is cleared by reading it
	always_ff @(posedge clock) begin
		if (reset) begin
			result <= '0;
			resultReady <= 1'b0;
		end else begin
			if (storeNow) begin
				result <= finalConc;
			end
			if (storeNow) begin
				resultReady <= 1'b1;
			end else if (readStrobe && wbAdr == ADDR_RESULT) begin
				resultReady <= 1'b0;
			end
		end
	end
endmodule

// file: testbench/mms_sequencer_props.sv
// Checker for bus answers and power state of the mode sequencer.
// Assumes the ports of mms_sequencer, one clock, synchronous reset.
`timescale 1ns/1ps
module mms_sequencer_props
	import mms_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Bus
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [7:0] wbAdr,
	input wire logic [31:0] wbDatR,
	input wire logic wbAck,
	// Front end and pins
	input wire logic seqStart,
	input wire logic seqDone,
	input wire logic serviceReq,
	input wire logic pulse_output_disable_pin,
	input wire logic powerActive
);
	// Set once software has chosen a mode since the last reset
	logic armed;
	always_ff @(posedge clock) begin
		if (reset) begin
			armed <= 1'b0;
		end else if (wbAck && wbWe && wbAdr == ADDR_CTRL) begin
			armed <= 1'b1;
		end
	end
	default clocking @(posedge clock);
	endclocking
	default disable iff (reset);
	AST_ACK_NEXT: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
		else $error("bus access not acknowledged next cycle");
	AST_ACK_PULSE: assert property (wbAck |=> !wbAck)
		else $error("acknowledge held too long");
	AST_UNMAPPED_ZERO: assert property (wbCyc && wbStb && !wbWe && !wbAck
		&& wbAdr == 8'h20 |=> wbDatR == 32'h0)
		else $error("unmapped read not zero");
	AST_DATR_HOLD: assert property (!$stable(wbDatR) |-> wbAck && !wbWe)
		else $error("read data changed outside a read");
	AST_START_PULSE: assert property (seqStart |=> !seqStart)
		else $error("start pulse longer than one cycle");
	AST_START_AWAKE: assert property (seqStart |-> powerActive)
		else $error("sequence started while inactive");
	AST_DONE_SLEEP: assert property (seqDone && powerActive
		|-> ##[1:60] !powerActive)
		else $error("no return to inactive after a sequence");
	AST_SERVICE_SPAN: assert property ($rose(powerActive) && !seqStart
		|-> powerActive [*8] ##[1:40] !powerActive)
		else $error("service wake not brief");
	AST_IDLE_START: assert property (!armed && pulse_output_disable_pin
		|-> !seqStart)
		else $error("measurement in power-up idle mode");
	cover property (seqStart && !armed);
	cover property (seqDone ##[1:60] $fell(powerActive));
	cover property (serviceReq && !powerActive);
endmodule
bind mms_sequencer mms_sequencer_props u_mms_sequencer_props (.clock(clock),
	.reset(reset), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
	.wbDatR(wbDatR), .wbAck(wbAck), .seqStart(seqStart), .seqDone(seqDone),
	.serviceReq(serviceReq),
	.pulse_output_disable_pin(pulse_output_disable_pin),
	.powerActive(powerActive));

// file: testbench/mms_front_end.sv
// Behavioural measurement front end: one done pulse per start pulse.
// Assumes the sequencer's clock; delay and value set by the bench.
`timescale 1ns/1ps
module mms_front_end (
	// Clock
	input wire logic clock,
	// Sequencer side
	input wire logic seqStart,
	output logic seqDone,
	output logic [15:0] rawConc,
	// Bench control
	input wire logic [7:0] delay,
	input wire logic [15:0] rawValue
);
	logic [7:0] count;
	logic busy = 1'b0;
	initial seqDone = 1'b0;
	always @(posedge clock) begin
		seqDone <= 1'b0;
		if (seqStart) begin
			busy <= 1'b1;
			count <= delay;
		end else if (busy && count == 8'h00) begin
			busy <= 1'b0;
			seqDone <= 1'b1;
		end else if (busy) begin
			count <= count - 8'h01;
		end
	end
	// Value is only meaningful with the done pulse, so show junk otherwise
	assign rawConc = seqDone ? rawValue : ~rawValue;
endmodule

// file: testbench/tb.sv
// Self-checking bench for the measurement mode sequencer.
// Assumes shortened second and week counts and the behavioural front end.
`timescale 1ns/1ps
module tb;
	import mms_pkg::*;
	logic clock = 1'b0, reset = 1'b1, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
	logic [7:0] wbAdr = 8'h00, delay = 8'h03;
	logic [3:0] wbSel = 4'hF;
	logic [31:0] wbDatW = 32'h0, wbDatR, q;
	logic wbAck, seqStart, seqDone, serviceReq = 1'b0, powerActive;
	logic pin = 1'b1;
	logic [15:0] rawConc, rawValue = 16'h01F4;
	int bad_count = 0, n_compared = 0;
	mms_sequencer #(.TICK_CYCLES(10), .WEEK_SECONDS(20)) u_mms_sequencer (
		.clock(clock), .reset(reset), .wbCyc(wbCyc), .wbStb(wbStb),
		.wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
		.wbDatR(wbDatR), .wbAck(wbAck), .seqStart(seqStart),
		.seqDone(seqDone), .rawConc(rawConc), .serviceReq(serviceReq),
		.pulse_output_disable_pin(pin), .powerActive(powerActive));
	mms_front_end u_mms_front_end (.clock(clock), .seqStart(seqStart),
		.seqDone(seqDone), .rawConc(rawConc), .delay(delay),
		.rawValue(rawValue));
	initial begin
		forever #5 clock = ~clock;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("compared=%0d mismatches=%0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Classic cycle: hold everything until ack is seen at an edge
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbDatW <= d;
		do begin
			@(posedge clock);
			n++;
		end while (wbAck !== 1'b1 && n < 50);
		q = wbDatR;
		if (n >= 50) bad_count++;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge clock);
	endtask
	task automatic do_reset();
		reset <= 1'b1;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (powerActive !== 1'b1 && n < 500) begin
			@(posedge clock);
			n++;
		end
		while (powerActive !== 1'b0 && n < 500) begin
			@(posedge clock);
			n++;
		end
		if (n >= 500) bad_count++;
	endtask
	task automatic count_starts(input int cycles, output int k);
		k = 0;
		repeat (cycles) begin
			@(posedge clock);
			if (seqStart === 1'b1) k++;
		end
	endtask
	task automatic t_defaults();
		do_reset();
		wb(1'b0, ADDR_STATUS, 32'h0);
		check(q, 32'h0);
		wb(1'b0, ADDR_PERIOD, 32'h0);
		check(q, 32'h3C);
		wb(1'b0, ADDR_PRESS_HIGH, 32'h0);
		check(q, 32'h03);
		wb(1'b0, ADDR_PRESS_LOW, 32'h0);
		check(q, 32'hF5);
		wb(1'b0, ADDR_SETPOINT, 32'h0);
		check(q, 32'h190);
		wb(1'b1, ADDR_PERIOD, 32'hFFF);
		wb(1'b0, ADDR_PERIOD, 32'h0);
		check(q, 32'hFFF);
		wb(1'b1, 8'h20, 32'hFFFF_FFFF);
		wb(1'b0, 8'h20, 32'h0);
		check(q, 32'h0);
	endtask
	task automatic t_single();
		int k;
		do_reset();
		rawValue <= 16'h01F4;
		wb(1'b1, ADDR_PRESS_HIGH, 32'h07);
		wb(1'b1, ADDR_PRESS_LOW, 32'hEA);
		wb(1'b1, ADDR_CTRL, 32'h2);
		wait_idle();
		wb(1'b0, ADDR_RESULT, 32'h0);
		check(q, 32'h3E8);
		wb(1'b0, ADDR_STATUS, 32'h0);
		check(q, 32'h0);
		count_starts(150, k);
		check(k, 0);
	endtask
	task automatic t_cont();
		int k, gap;
		logic slept;
		do_reset();
		delay <= 8'd20;
		wb(1'b1, ADDR_PERIOD, 32'h6);
		wb(1'b1, ADDR_CTRL, 32'h1);
		k = 0;
		while (seqStart !== 1'b1 && k < 200) begin
			@(posedge clock);
			k++;
		end
		gap = 0;
		slept = 1'b0;
		do begin
			@(posedge clock);
			gap++;
			if (powerActive === 1'b0) slept = 1'b1;
		end while (seqStart !== 1'b1 && gap < 200);
		check(gap > 50 && gap <= 70, 1);
		check(slept, 1'b1);
		wb(1'b1, ADDR_CTRL, 32'h0);
		wait_idle();
		count_starts(150, k);
		check(k, 0);
		delay <= 8'd3;
	endtask
	task automatic t_service();
		int k;
		do_reset();
		serviceReq <= 1'b1;
		@(posedge clock);
		serviceReq <= 1'b0;
		k = 0;
		repeat (40) begin
			@(posedge clock);
			if (powerActive === 1'b1) k++;
		end
		check(k, SERVICE_CYCLES);
	endtask
	task automatic t_pin();
		pin <= 1'b0;
		do_reset();
		repeat (6) @(posedge clock);
		wb(1'b0, ADDR_STATUS, 32'h0);
		check(q[3:2], 2'b01);
		wb(1'b1, ADDR_CTRL, 32'h0);
		pin <= 1'b1;
		wb(1'b0, ADDR_STATUS, 32'h0);
		check(q[3:2], 2'b00);
	endtask
	task automatic t_baseline();
		do_reset();
		rawValue <= 16'h01C2;
		wb(1'b1, ADDR_PERIOD, 32'h5);
		wb(1'b1, ADDR_CTRL, 32'h5);
		repeat (260) @(posedge clock);
		wb(1'b0, ADDR_STATUS, 32'h0);
		check(q[5], 1'b1);
		wb(1'b0, ADDR_OFFSET, 32'h0);
		check(q, 32'hFFFF_FFCE);
		repeat (80) @(posedge clock);
		wb(1'b0, ADDR_RESULT, 32'h0);
		check(q, 32'h190);
	endtask
	initial begin
		#300000;
		bad_count++;
		end_sim();
	end
	initial begin
		t_defaults();
		t_single();
		t_cont();
		t_service();
		t_pin();
		t_baseline();
		end_sim();
	end
endmodule
